/* hdl/bsp_device.sv */
// bsp_device: sensor end of the command port, spi or i2c chosen by strap.
// assumes link pins are asynchronous to clk; the sensor core is modelled
// by two sample inputs; the one chosen by the conversion kind is captured at the end.
//
// Summary of operation
// - host reads calibration memory after every reset; the bench does so only in t_cal, not after the reset command in t_conv
// - eight 16-bit calibration words held
// - calibration read: command byte, 16-bit reply, msb first
// - i2c transactions framed by start and stop
// - i2c address 111011 plus inverted select pin
// - reset command accepted at any time
// - host frees stuck data line with clocks, reset; bsp_host has no such recovery sequence
// - i2c calibration read uses write then read
// - busy until conversion done, result after that
// - i2c result read: 24 bits, ack per byte
// - 4-bit crc stored inside calibration memory
// - strap high selects i2c, low selects spi
// - decode reset, conversions, result read, memory read
// - empty, repeated or early result read returns zero
// - spi clock modes 0 and 3 both accepted
`timescale 1ns/10ps
`default_nettype none
module bsp_device #(
   parameter int unsigned    CONV_CYC = bsp_pkg::CONV_BASE_CYC,  // cycles at lowest ratio
   parameter logic [127:0]   CAL_INIT = bsp_pkg::CAL_INIT_DEF    // word 0 in top bits
) (
   input  wire logic         clk,
   input  wire logic         rst,
   input  wire logic         protocol_select_pin,  // strap, high = i2c
   bsp_if.device             bus,
   input  wire logic [23:0]  pressure_sample,      // sensor core pressure value
   input  wire logic [23:0]  temperature_sample,   // sensor core temperature value
   output var  logic         conv_busy             // conversion in progress
);
   import bsp_pkg::*;

   // insert the crc nibble into the low bits of word 7
   function automatic logic [127:0] cal_with_crc(input logic [127:0] cal);
      logic [127:0] m;
      logic [15:0]  rem;
      m = cal;
      m[7:0] = 8'h00;
      rem = 16'h0000;
      for (int c = 0; c < 16; c++) begin
         rem = rem ^ {8'h00, m[127 - 8*c -: 8]};
         for (int k = 0; k < 8; k++) begin
            rem = rem[15] ? ({rem[14:0], 1'b0} ^ 16'h3000) : {rem[14:0], 1'b0};
         end
      end
      m = cal;
      m[3:0] = rem[15:12];
      return m;
   endfunction : cal_with_crc

   localparam logic [127:0] CAL_MEM = cal_with_crc(CAL_INIT);

   typedef enum logic [2:0] {
      D_IDLE  = 3'h0,   // bus idle or not addressed
      D_ADDR  = 3'h1,   // receiving address byte
      D_AACK  = 3'h3,   // driving address ack
      D_CMD   = 3'h2,   // receiving command byte
      D_CACK  = 3'h6,   // driving command ack
      D_TX    = 3'h7,   // sending reply bits
      D_TXACK = 3'h5,   // host ack slot
      D_WAIT  = 3'h4    // ignore until stop or start
   } bsp_dst_t;

   // two-stage synchronisers: sclk, select, data line, strap
   logic [3:0]   meta_q;            // first stage, read only by sync_q
   logic [3:0]   sync_q;            // second stage
   logic         sclk_prev_q;       // last synced clock level
   logic         sda_prev_q;        // last synced data level
   logic         i2c_q;             // latched protocol choice
   bsp_dst_t     st_q, st_d;        // i2c byte state
   logic [3:0]   cnt_q, cnt_d;      // bit counter
   logic [7:0]   sr_q, sr_d;        // receive shifter
   logic [23:0]  tx_q, tx_d;        // transmit shifter
   logic [23:0]  resp_q, resp_d;    // reply staged by last command
   logic [23:0]  res_q, res_d;      // finished conversion result
   logic         rw_q, rw_d;        // i2c read direction
   logic         oe_q, oe_d;        // data line pull-down
   logic         out_q, out_d;      // spi reply pin
   logic         busy_q, busy_d;    // conversion running
   logic         temp_q, temp_d;    // conversion kind, 1 = temperature
   logic [31:0]  cc_q, cc_d;        // conversion countdown

   logic sclk_s, sel_s, sda_s;     // synced pins
   logic rise, fall, start, stop;  // link events
   logic exec;                     // a command byte is complete
   logic [7:0] cmd;                // completed command byte
   logic load;                     // spi: stage reply into shifter

   assign sclk_s = sync_q[0];
   assign sel_s  = sync_q[1];
   assign sda_s  = sync_q[2];
   assign rise   = sclk_s & ~sclk_prev_q;
   assign fall   = ~sclk_s & sclk_prev_q;
   assign start  = sclk_s & sclk_prev_q & sda_prev_q & ~sda_s;
   assign stop   = sclk_s & sclk_prev_q & ~sda_prev_q & sda_s;

   // synchronisers and strap capture while reset is held
   always_ff @(posedge clk) begin
      meta_q      <= {protocol_select_pin, bus.serial_in_pin, bus.select_low_pin, bus.sclk};
      sync_q      <= meta_q;
      sclk_prev_q <= sync_q[0];
      sda_prev_q  <= sync_q[2];
      if (rst) begin
         i2c_q <= sync_q[3];
      end
   end

   // next-state logic for both protocols and the converter
   always_comb begin
      st_d   = st_q;
      cnt_d  = cnt_q;
      sr_d   = sr_q;
      tx_d   = tx_q;
      resp_d = resp_q;
      res_d  = res_q;
      rw_d   = rw_q;
      oe_d   = oe_q;
      busy_d = busy_q;
      temp_d = temp_q;
      cc_d   = cc_q;
      exec   = 1'b0;
      cmd    = 8'h00;
      load   = 1'b0;

      // conversion countdown, result captured at the end
      if (busy_q) begin
         if (cc_q <= 32'h1) begin
            busy_d = 1'b0;
            res_d  = temp_q ? temperature_sample : pressure_sample;
         end else begin
            cc_d = cc_q - 32'h1;
         end
      end

      if (!i2c_q) begin
         // spi: sample on rising edges, both idle polarities alike
         oe_d = 1'b0;
         if (sel_s) begin
            cnt_d = 4'h0;
            tx_d  = 24'h0;
         end else if (rise) begin
            if (cnt_q < 4'h8) begin
               sr_d  = {sr_q[6:0], sda_s};
               cnt_d = cnt_q + 4'h1;
               if (cnt_q == 4'h7) begin
                  exec = 1'b1;
                  cmd  = {sr_q[6:0], sda_s};
                  load = 1'b1;
               end
            end else begin
               tx_d = {tx_q[22:0], 1'b0};
            end
         end
      end else if (stop) begin
         st_d = D_IDLE;
         oe_d = 1'b0;
      end else if (start) begin
         st_d  = D_ADDR;
         cnt_d = 4'h0;
         oe_d  = 1'b0;
      end else begin
         unique case (st_q)
            D_ADDR, D_CMD: begin
               if (rise && cnt_q < 4'h8) begin
                  sr_d  = {sr_q[6:0], sda_s};
                  cnt_d = cnt_q + 4'h1;
               end else if (fall && cnt_q == 4'h8) begin
                  cnt_d = 4'h0;
                  if (st_q == D_CMD) begin
                     oe_d = 1'b1;
                     st_d = D_CACK;
                     exec = 1'b1;
                     cmd  = sr_q;
                  end else if (sr_q[7:1] == {ADDR_HI, ~sel_s}) begin
                     oe_d = 1'b1;
                     rw_d = sr_q[0];
                     st_d = D_AACK;
                  end else begin
                     st_d = D_IDLE;
                  end
               end
            end
            D_AACK: begin
               if (fall) begin
                  if (rw_q) begin
                     st_d  = D_TX;
                     tx_d  = resp_q;
                     oe_d  = ~resp_q[23];
                     cnt_d = 4'h1;
                  end else begin
                     st_d = D_CMD;
                     oe_d = 1'b0;
                  end
               end
            end
            D_CACK: begin
               if (fall) begin
                  oe_d = 1'b0;
                  st_d = D_WAIT;
               end
            end
            D_TX: begin
               if (fall) begin
                  if (cnt_q == 4'h8) begin
                     oe_d = 1'b0;
                     st_d = D_TXACK;
                  end else begin
                     tx_d  = {tx_q[22:0], 1'b0};
                     oe_d  = ~tx_q[22];
                     cnt_d = cnt_q + 4'h1;
                  end
               end
            end
            D_TXACK: begin
               if (rise && sda_s) begin
                  st_d = D_WAIT;                                           // host nack ends reply
               end else if (fall) begin
                  tx_d  = {tx_q[22:0], 1'b0};
                  oe_d  = ~tx_q[22];
                  cnt_d = 4'h1;
                  st_d  = D_TX;
               end
            end
            D_IDLE, D_WAIT: begin
               oe_d = 1'b0;
            end
            default: begin
               st_d = D_IDLE;
               oe_d = 1'b0;
            end
         endcase
      end

      // command execution, shared by both protocols
      if (exec) begin
         if (cmd == CMD_RESET) begin
            busy_d = 1'b0;
            res_d  = 24'h0;
            resp_d = 24'h0;
         end else if (is_conv(cmd)) begin
            busy_d = 1'b1;
            temp_d = cmd[4];
            cc_d   = CONV_CYC << cmd[3:1];
         end else if (cmd == CMD_ADC_READ) begin
            resp_d = busy_q ? 24'h0 : res_q;
            res_d  = busy_q ? res_d : 24'h0;
         end else if (is_cal(cmd)) begin
            resp_d = {CAL_MEM[127 - 16*cmd[3:1] -: 16], 8'h00};
         end
      end
      if (load) begin
         tx_d = resp_d;
      end
      out_d = ~i2c_q & ~sel_s & tx_d[23];
   end

   // state registers
   always_ff @(posedge clk) begin
      if (rst) begin
         st_q   <= D_IDLE;
         cnt_q  <= 4'h0;
         sr_q   <= 8'h00;
         tx_q   <= 24'h0;
         resp_q <= 24'h0;
         res_q  <= 24'h0;
         rw_q   <= 1'b0;
         oe_q   <= 1'b0;
         out_q  <= 1'b0;
         busy_q <= 1'b0;
         temp_q <= 1'b0;
         cc_q   <= 32'h0;
      end else begin
         st_q   <= st_d;
         cnt_q  <= cnt_d;
         sr_q   <= sr_d;
         tx_q   <= tx_d;
         resp_q <= resp_d;
         res_q  <= res_d;
         rw_q   <= rw_d;
         oe_q   <= oe_d;
         out_q  <= out_d;
         busy_q <= busy_d;
         temp_q <= temp_d;
         cc_q   <= cc_d;
      end
   end

   assign bus.dev_sda_out    = 1'b0;    // open drain: only pulls low
   assign bus.dev_sda_oe     = oe_q;
   assign bus.serial_out_pin = out_q;
   assign conv_busy          = busy_q;

endmodule : bsp_device
`default_nettype wire

/* hdl/bsp_host.sv */
// bsp_host: controller end; sends one command and collects its reply.
// assumes the device shares clk; the serial clock is divided from clk.
`timescale 1ns/10ps
`default_nettype none
module bsp_host #(
   parameter int unsigned HALF = bsp_pkg::HALF_CYC  // serial half period, cycles
) (
   input  wire logic         clk,
   input  wire logic         rst,
   input  wire logic         i2c_mode,      // 1 = i2c framing, 0 = spi mode 0
   input  wire logic         addr_lsb,      // address bit 0 (inverted select strap)
   input  wire logic         cmd_valid,     // command request
   input  wire logic [7:0]   cmd_byte,      // command code
   output var  logic         cmd_ready,     // idle, request taken
   output var  logic         rsp_valid,     // one-cycle reply strobe
   output var  logic [23:0]  rsp_data,      // reply, right aligned
   bsp_if.host               bus
);
   import bsp_pkg::*;

   typedef enum logic [2:0] {
      H_IDLE  = 3'h0, H_START = 3'h1, H_LOW = 3'h3, H_HIGH = 3'h2,
      H_STOPA = 3'h6, H_STOPB = 3'h7, H_DONE = 3'h5
   } bsp_hst_t;

   // frame builder: bits to send and which sampled bits are reply data
   function automatic void frame(input logic i2c, input logic rd, input logic [7:0] c,
                                 input logic a0, output logic [35:0] v,
                                 output logic [35:0] m, output logic [5:0] n);
      logic [1:0] nb;
      nb = rsp_bytes(c);
      v  = '1;
      m  = '0;
      n  = 6'(8 + 8 * nb);
      if (!i2c) begin
         v[35:28] = c;
         m[27:4]  = (nb == 2'h3) ? 24'hFFFFFF : 24'hFFFF00;
      end else if (!rd) begin
         v[35:18] = {ADDR_HI, a0, 1'b0, 1'b1, c, 1'b1};
         n = 6'd18;
      end else begin
         v[35:27] = {ADDR_HI, a0, 1'b1, 1'b1};
         for (int b = 0; b < 3; b++) begin
            m[26 - 9*b -: 8] = (b < nb) ? 8'hFF : 8'h00;
            v[18 - 9*b] = (b + 1 >= nb);                 // nack after last byte
         end
         n = 6'(9 + 9 * nb);
      end
   endfunction : frame

   bsp_hst_t     st_q, st_d;      // sequencer state
   logic [7:0]   div_q, div_d;    // half-period counter
   logic [35:0]  vec_q, vec_d;    // bits to send
   logic [35:0]  cap_q, cap_d;    // capture mask
   logic [5:0]   n_q, n_d;        // bits left
   logic [23:0]  rx_q, rx_d;      // collected reply
   logic [7:0]   cmd_q, cmd_d;    // command in flight
   logic         i2c_q, i2c_d;    // framing for this command
   logic         rd_q, rd_d;      // second i2c transaction begun
   logic         scl_q, scl_d;    // serial clock pin
   logic         sel_q, sel_d;    // select pin
   logic         sdo_q, sdo_d;    // data drive value
   logic         soe_q, soe_d;    // data drive enable
   logic         rv_q, rv_d;      // reply strobe
   logic         tick;            // half period elapsed
   logic [35:0]  fv, fm;          // frame builder outputs
   logic [5:0]   fn;

   assign tick = (div_q == 8'h00);

   // sequencer next state
   always_comb begin
      st_d = st_q;  div_d = tick ? 8'(HALF - 1) : div_q - 8'h01;
      vec_d = vec_q;  cap_d = cap_q;  n_d = n_q;  rx_d = rx_q;
      cmd_d = cmd_q;  i2c_d = i2c_q;  rd_d = rd_q;  scl_d = scl_q;
      sel_d = sel_q;  sdo_d = sdo_q;  soe_d = soe_q;  rv_d = 1'b0;
      frame(i2c_q, 1'b1, cmd_q, addr_lsb, fv, fm, fn);
      unique case (st_q)
         H_IDLE: begin
            scl_d = i2c_mode;
            soe_d = ~i2c_mode;
            sdo_d = 1'b0;
            sel_d = 1'b1;
            if (cmd_valid) begin
               frame(i2c_mode, 1'b0, cmd_byte, addr_lsb, vec_d, cap_d, n_d);
               cmd_d = cmd_byte;  i2c_d = i2c_mode;  rd_d = 1'b0;
               rx_d = 24'h0;  st_d = H_START;  div_d = 8'(HALF - 1);
               sel_d = i2c_mode;  soe_d = 1'b1;
            end
         end
         H_START: if (tick) begin
            scl_d = 1'b0;  st_d = H_LOW;
            sdo_d = ~i2c_q & vec_q[35];
            soe_d = ~i2c_q | ~vec_q[35];
         end
         H_LOW: if (tick) begin
            scl_d = 1'b1;  st_d = H_HIGH;
            if (!i2c_q && cap_q[35]) rx_d = {rx_q[22:0], bus.serial_out_pin};
         end
         H_HIGH: if (tick) begin
            scl_d = 1'b0;
            if (i2c_q && cap_q[35]) rx_d = {rx_q[22:0], bus.serial_in_pin};
            vec_d = {vec_q[34:0], 1'b1};  cap_d = {cap_q[34:0], 1'b0};
            n_d = n_q - 6'h01;
            if (n_q == 6'h01) begin
               st_d = H_STOPA;  soe_d = 1'b1;  sdo_d = 1'b0;
            end else begin
               st_d  = H_LOW;
               sdo_d = ~i2c_q & vec_q[34];
               soe_d = ~i2c_q | ~vec_q[34];
            end
         end
         H_STOPA: if (tick) begin
            st_d  = i2c_q ? H_STOPB : H_DONE;
            scl_d = i2c_q;  sel_d = 1'b1;
         end
         H_STOPB: if (tick) begin
            st_d = H_DONE;  soe_d = 1'b0;
         end
         H_DONE: if (tick) begin
            if (i2c_q && !rd_q && rsp_bytes(cmd_q) != 2'h0) begin
               vec_d = fv;  cap_d = fm;  n_d = fn;
               rd_d = 1'b1;  st_d = H_START;  soe_d = 1'b1;
            end else begin
               rv_d = 1'b1;  st_d = H_IDLE;
            end
         end
         default: st_d = H_IDLE;
      endcase
   end

   // sequencer registers
   always_ff @(posedge clk) begin
      if (rst) begin
         st_q <= H_IDLE;  div_q <= 8'h00;  vec_q <= '1;  cap_q <= '0;
         n_q <= 6'h00;  rx_q <= 24'h0;  cmd_q <= 8'h00;  i2c_q <= 1'b0;
         rd_q <= 1'b0;  scl_q <= 1'b0;  sel_q <= 1'b1;  sdo_q <= 1'b0;
         soe_q <= 1'b0;  rv_q <= 1'b0;
      end else begin
         st_q <= st_d;  div_q <= div_d;  vec_q <= vec_d;  cap_q <= cap_d;
         n_q <= n_d;  rx_q <= rx_d;  cmd_q <= cmd_d;  i2c_q <= i2c_d;
         rd_q <= rd_d;  scl_q <= scl_d;  sel_q <= sel_d;  sdo_q <= sdo_d;
         soe_q <= soe_d;  rv_q <= rv_d;
      end
   end

   assign cmd_ready          = (st_q == H_IDLE);
   assign rsp_valid          = rv_q;
   assign rsp_data           = rx_q;
   assign bus.sclk           = scl_q;
   assign bus.select_low_pin = sel_q;
   assign bus.host_sdi_out   = sdo_q;
   assign bus.host_sdi_oe    = soe_q;

endmodule : bsp_host
`default_nettype wire

/* hdl/bsp_if.sv */
// bsp_if: serial wires between the sensor end and the host end.
// assumes the open-drain data line is pulled high when nobody drives it.
`timescale 1ns/10ps
`default_nettype none
interface bsp_if;
   logic sclk;             // serial clock, made by the host
   logic select_low_pin;   // chip select (spi) or address strap (i2c), active low
   logic host_sdi_out;     // host drive value on serial_in_pin
   logic host_sdi_oe;      // host drives serial_in_pin
   logic dev_sda_out;      // device drive value on serial_in_pin
   logic dev_sda_oe;       // device drives serial_in_pin
   logic serial_in_pin;    // resolved data line level
   logic serial_out_pin;   // spi reply data

   // wired-and of both drivers, pulled high when idle
   assign serial_in_pin = (host_sdi_oe ? host_sdi_out : 1'b1) &
                          (dev_sda_oe ? dev_sda_out : 1'b1);

   modport device (input sclk, select_low_pin, serial_in_pin,
                   output dev_sda_out, dev_sda_oe, serial_out_pin);
   modport host (output sclk, select_low_pin, host_sdi_out, host_sdi_oe,
                 input serial_in_pin, serial_out_pin);
endinterface : bsp_if
`default_nettype wire

/* hdl/bsp_pkg.sv */
// bsp_pkg: constants and helpers shared by both ends of the sensor port.
// assumes a 100 MHz system clock on both ends.
package bsp_pkg;

   localparam int unsigned CLK_NS       = 10;      // system clock period
   localparam int unsigned CONV_BASE_NS = 1000;    // conversion time at lowest oversampling
   localparam int unsigned CONV_BASE_CYC = (CONV_BASE_NS + CLK_NS - 1) / CLK_NS;
   localparam int unsigned HALF_CYC     = 4;       // host serial clock half period, cycles

   localparam logic [7:0] CMD_RESET    = 8'h1E;    // device reset
   localparam logic [7:0] CMD_ADC_READ = 8'h00;    // read conversion result
   localparam logic [7:0] CMD_CONV_P   = 8'h40;    // raw_pressure_conversion base
   localparam logic [7:0] CMD_CONV_T   = 8'h50;    // raw_temperature_conversion base
   localparam logic [7:0] CMD_CAL_RD   = 8'hA0;    // calibration_memory read base
   localparam logic [5:0] ADDR_HI      = 6'h3B;    // fixed upper address bits 111011
   localparam int unsigned CAL_WORDS   = 8;        // calibration words
   localparam int unsigned HOST_VEC_W  = 36;       // longest host bit frame
   localparam logic [2:0] OSR_MAX      = 3'h4;     // highest oversampling index

   // default calibration contents (word 0 first); values are arbitrary
   localparam logic [127:0] CAL_INIT_DEF = 128'h0A5A_1234_2345_3456_4567_5678_6789_C3C0;

   // conversion command: 0x40..0x48 or 0x50..0x58, even codes only
   function automatic logic is_conv(input logic [7:0] c);
      return (c[7:5] == 3'h2) && (c[3:1] <= OSR_MAX) && !c[0];
   endfunction : is_conv

   // calibration read command: 0xA0..0xAE, even codes only
   function automatic logic is_cal(input logic [7:0] c);
      return (c[7:4] == 4'hA) && !c[0];
   endfunction : is_cal

   // number of reply bytes a command produces
   function automatic logic [1:0] rsp_bytes(input logic [7:0] c);
      if (c == CMD_ADC_READ) return 2'h3;
      if (is_cal(c)) return 2'h2;
      return 2'h0;
   endfunction : rsp_bytes

endpackage : bsp_pkg

/* testbench/baro_sensor_serial_command_port_tb_top.sv */
// baro_sensor_serial_command_port_tb_top: both ends joined over spi and i2c.
// assumes the host end makes the link clock; sensor samples come from here.
`timescale 1ns/10ps
`default_nettype none
module baro_sensor_serial_command_port_tb_top;
   import bsp_pkg::*;
   localparam int unsigned CV    = 16;          // short conversion base, cycles
   localparam int unsigned LIMIT = 60000;       // cycle ceiling for the whole run
   localparam logic [23:0] P_SMP = 24'h5A1234;  // pressure sample value
   localparam logic [23:0] T_SMP = 24'hC3A5F0;  // temperature sample value
   logic        clk       = 1'b0;     // system clock
   logic        rst       = 1'b1;     // synchronous reset
   logic        mode      = 1'b0;     // 1 = i2c on both ends
   logic        cmd_valid = 1'b0;     // host command request
   logic [7:0]  cmd_byte  = 8'h00;    // host command code
   logic [23:0] psmp      = P_SMP;    // pressure sample
   logic [23:0] tsmp      = T_SMP;    // temperature sample
   logic [23:0] rr;                   // reply taken from the host end
   logic        cmd_ready, rsp_valid, conv_busy;
   logic [23:0] rsp_data;             // host reply
   int          checks = 0, n_mismatch = 0, cyc = 0;
   bsp_if bus ();
   // sensor end, strap follows the bench mode
   bsp_device #(.CONV_CYC(CV), .CAL_INIT(CAL_INIT_DEF)) u_bsp_device (
      .clk                 (clk),
      .rst                 (rst),
      .protocol_select_pin (mode),
      .bus                 (bus),
      .pressure_sample     (psmp),
      .temperature_sample  (tsmp),
      .conv_busy           (conv_busy)
   );
   // host end; it holds select high in i2c, so address bit 0 is zero
   bsp_host #(.HALF(HALF_CYC)) u_bsp_host (
      .clk       (clk),
      .rst       (rst),
      .i2c_mode  (mode),
      .addr_lsb  (1'b0),
      .cmd_valid (cmd_valid),
      .cmd_byte  (cmd_byte),
      .cmd_ready (cmd_ready),
      .rsp_valid (rsp_valid),
      .rsp_data  (rsp_data),
      .bus       (bus)
   );
   // link checks beside the interface
   bsp_asserts u_bsp_asserts (
      .clk            (clk),
      .rst            (rst),
      .sclk           (bus.sclk),
      .select_low_pin (bus.select_low_pin),
      .host_sdi_oe    (bus.host_sdi_oe),
      .dev_sda_out    (bus.dev_sda_out),
      .dev_sda_oe     (bus.dev_sda_oe),
      .serial_out_pin (bus.serial_out_pin)
   );

   // system clock, 10 ns period
   always #5 clk = ~clk;

   // report and end the run
   task automatic give_verdict();
      $display("checks=%0d n_mismatch=%0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : give_verdict

   // watchdog: a hang counts as a mismatch
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == LIMIT) begin
         n_mismatch++;
         give_verdict();
      end
   end

   // compare one value
   task automatic check(input logic [23:0] seen, input logic [23:0] exp);
      checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   // reset both ends in a mode, then let the link settle before a request
   task automatic do_reset(input logic m);
      @(posedge clk);
      rst  <= 1'b1;
      mode <= m;
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      repeat (10) @(posedge clk);
   endtask : do_reset

   // one command: request held for one cycle, reply taken with its strobe
   task automatic run_cmd(input logic [7:0] c, output logic [23:0] r);
      @(posedge clk);
      cmd_valid <= 1'b1;
      cmd_byte  <= c;
      @(posedge clk);
      cmd_valid <= 1'b0;
      do @(posedge clk); while (!rsp_valid);
      r = rsp_data;
   endtask : run_cmd

   // reset command, then calibration words after it
   task automatic t_cal();
      run_cmd(CMD_RESET, rr);
      run_cmd(CMD_CAL_RD, rr);
      check(rr, {8'h00, CAL_INIT_DEF[127:112]});
      run_cmd(CMD_CAL_RD | 8'h06, rr);
      check(rr, {8'h00, CAL_INIT_DEF[79:64]});
   endtask : t_cal

   // conversions, early and repeated reads, reset during conversion
   task automatic t_conv();
      run_cmd(CMD_CONV_P | 8'h08, rr);
      check({23'h0, conv_busy}, 24'h000001);
      run_cmd(CMD_ADC_READ, rr);
      check(rr, 24'h0);
      while (conv_busy) @(posedge clk);
      run_cmd(CMD_ADC_READ, rr);
      check(rr, P_SMP);
      run_cmd(CMD_ADC_READ, rr);
      check(rr, 24'h0);
      run_cmd(CMD_CONV_T, rr);
      while (conv_busy) @(posedge clk);
      run_cmd(CMD_ADC_READ, rr);
      check(rr, T_SMP);
      run_cmd(CMD_CONV_T | 8'h08, rr);
      run_cmd(CMD_RESET, rr);
      check({23'h0, conv_busy}, 24'h0);
      run_cmd(CMD_ADC_READ, rr);
      check(rr, 24'h0);
   endtask : t_conv

   // spi first, then a mid-run reset into i2c
   initial begin
      do_reset(1'b0);
      t_cal();
      t_conv();
      do_reset(1'b1);
      t_cal();
      t_conv();
      give_verdict();
   end
endmodule : baro_sensor_serial_command_port_tb_top
`default_nettype wire

/* testbench/bsp_asserts.sv */
// bsp_asserts: link checks between the two ends of the sensor port.
// assumes one clk domain and a host serial half period of 4 cycles.
`timescale 1ns/10ps
`default_nettype none
module bsp_asserts (
   input wire logic clk,
   input wire logic rst,
   input wire logic sclk,
   input wire logic select_low_pin,
   input wire logic host_sdi_oe,
   input wire logic dev_sda_out,
   input wire logic dev_sda_oe,
   input wire logic serial_out_pin
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   // reset seen on two edges in a row
   sequence s_rst2;
      rst ##1 rst;
   endsequence
   // serial clock held high for a whole half period
   sequence s_hi_half;
      sclk [*4];
   endsequence
   a_sda_pull_only: assert property (dev_sda_oe |-> !dev_sda_out)
      else $error("device drove the data line high");
   a_dev_rst_quiet: assert property (disable iff (1'b0)
      s_rst2 |-> !dev_sda_oe && !serial_out_pin)
      else $error("device drives the link during reset");
   a_host_rst_idle: assert property (disable iff (1'b0)
      s_rst2 |-> select_low_pin && !host_sdi_oe && !sclk)
      else $error("host not idle during reset");
   a_sda_hold_high: assert property (sclk && $past(sclk) |-> $stable(dev_sda_oe))
      else $error("device moved data while clock high");
   a_spi_out_hold: assert property (!select_low_pin && !sclk && !$past(sclk)
      |-> $stable(serial_out_pin))
      else $error("reply bit moved while clock low");
   a_spi_open_low: assert property ($fell(select_low_pin) |-> !sclk [*4])
      else $error("frame opened with clock high");
   a_sclk_half_len: assert property ($rose(sclk) |-> s_hi_half)
      else $error("serial clock high phase too short");
   a_ack_slot_len: assert property ($rose(dev_sda_oe) |-> dev_sda_oe [*8])
      else $error("device pull-down shorter than one bit");
endmodule : bsp_asserts
`default_nettype wire
